/* File: logic/plc_pkg.sv */
// Constants and types for the PWM level and CRC configuration bank.
// Assumes one master clock and a plain strobe register port.
// Overview of operation
// RULE1: Logic-high PWM period is high count plus low count, times time base.
// RULE2: Pin high for high count (bits 13:7) times time base each period.
// RULE3: Pin low for low count (bits 6:0) times time base each period.
// RULE4: High count zero with low count nonzero gives static low.
// RULE5: Low count zero with high count nonzero gives static high.
// RULE6: Both counts zero gives static low.
// RULE7: Sixteen-bit read/write spare register, resets to 5555h, no effect.
// RULE8: Sixteen-bit read/write section 1 expected CRC, resets to zero.
// RULE9: Bit 15 at 80h enables the CRC over addresses 80h to A3h; the code chains only 80h and 81h.
// RULE10: Bits 2:0 at 80h select the test DAC code, reset zero.
// RULE11: Bits 14:3 at 80h are reserved and read zero.
// RULE12: Register 81h resets to 8000h; bit 15 fixed one; spare bits read/write.
// RULE13: Two-bit time base selects 16, 64, 256 or 1024 master clocks.
// RULE14: Writes to reserved bits are ignored.
// RULE15: An enabled section CRC mismatch against the stored value flags a fault.
package plc_pkg;
    // Register addresses
    localparam logic [7:0]  ADDR_PWM_TB    = 8'h57;
    localparam logic [7:0]  ADDR_LH_PWM    = 8'h58;
    localparam logic [7:0]  ADDR_SPARE     = 8'h59;
    localparam logic [7:0]  ADDR_CRC1      = 8'h7e;
    localparam logic [7:0]  ADDR_CRC2_TDAC = 8'h80;
    localparam logic [7:0]  ADDR_GPIOA     = 8'h81;
    localparam logic [7:0]  ADDR_CRC_CTRL  = 8'ha4;
    localparam logic [7:0]  ADDR_CRC2      = 8'ha5;
    // Reset values
    localparam logic [15:0] RST_PWM_TB     = 16'h0000;
    localparam logic [15:0] RST_LH_PWM     = 16'h3f80;
    localparam logic [15:0] RST_SPARE      = 16'h5555;
    localparam logic [15:0] RST_CRC1       = 16'h0000;
    localparam logic [15:0] RST_CRC2_TDAC  = 16'h0000;
    localparam logic [15:0] RST_GPIOA      = 16'h8000;
    localparam logic [15:0] RST_CRC_CTRL   = 16'h0000;
    localparam logic [15:0] RST_CRC2       = 16'h0000;
    // Writable bits per register
    localparam logic [15:0] WM_PWM_TB      = 16'hc000;
    localparam logic [15:0] WM_LH_PWM      = 16'h3fff;
    localparam logic [15:0] WM_CRC2_TDAC   = 16'h8007;
    localparam logic [15:0] WM_GPIOA       = 16'h7fff;
    localparam logic [15:0] WM_CRC_CTRL    = 16'h8000;
    // Field positions
    localparam int          CNT_W          = 7;
    localparam int          LH_HC_LSB      = 7;
    localparam int          LH_LC_LSB      = 0;
    localparam int          TB_LSB         = 14;
    localparam int          CRC2_EN_BIT    = 15;
    localparam int          TDAC_LSB       = 0;
    localparam int          TDAC_W         = 3;
    localparam int          GA_DAT_LSB     = 0;
    localparam int          GA_TB0_LSB     = 4;
    localparam int          GA_TB1_LSB     = 6;
    localparam int          GA_DIR_LSB     = 8;
    localparam int          GA_FMT_LSB     = 10;
    localparam int          GA_FIX_BIT     = 15;
    localparam int          CRC1_EN_BIT    = 15;
    localparam int          FAULT1_BIT     = 0;
    localparam int          FAULT2_BIT     = 1;
    // Time base lengths in master clock cycles
    localparam logic [10:0] TB_CYC0        = 11'h010;
    localparam logic [10:0] TB_CYC1        = 11'h040;
    localparam logic [10:0] TB_CYC2        = 11'h100;
    localparam logic [10:0] TB_CYC3        = 11'h400;
    // CRC-16 shape
    localparam logic [15:0] CRC_POLY       = 16'h1021;
    localparam logic [15:0] CRC_INIT       = 16'hffff;

    typedef enum logic [2:0] {
        PS_STATIC = 3'h1,
        PS_HIGH   = 3'h2,
        PS_LOW    = 3'h4
    } plc_pwm_state_t;
endpackage : plc_pkg

/* File: logic/plc_pwm_gen.sv */
// PWM encoder for the logic-high level of the PWM-capable pin.
// Assumes counts and time base come straight from the register bank.
`timescale 1ns/1ps
`default_nettype none
module plc_pwm_gen
    import plc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             levelHigh,
    input  wire logic [CNT_W-1:0] highCount,
    input  wire logic [CNT_W-1:0] lowCount,
    input  wire logic [1:0]       timeBase,
    output logic                  pwmPin
);
    plc_pwm_state_t state_q, state_d;
    logic [9:0]     preCnt_q, preCnt_d;
    logic [7:0]     slot_q, slot_d;
    logic [10:0]    tbLen;
    logic [7:0]     period;
    logic           tick;

    ////////////////////////////////////////////////////////////////
    // RULE13 time base length
    always_comb begin
        unique case (timeBase)
            2'h0: tbLen = TB_CYC0;
            2'h1: tbLen = TB_CYC1;
            2'h2: tbLen = TB_CYC2;
            2'h3: tbLen = TB_CYC3;
        endcase
    end

    // RULE1 period in time base slots
    assign period = {1'b0, highCount} + {1'b0, lowCount};
    // A shorter time base cuts the running slot short instead of waiting for wrap
    assign tick   = (preCnt_q >= 10'(tbLen - 11'h001));

    always_comb begin
        preCnt_d = tick ? 10'h000 : preCnt_q + 10'h001;
        slot_d   = slot_q;
        if (tick) begin
            slot_d = (slot_q + 8'h01 >= period) ? 8'h00 : slot_q + 8'h01;
        end
        // Low level encoding lives elsewhere; here it stays static low
        if (!levelHigh) begin
            state_d = PS_STATIC;
        // RULE4 RULE6 no high time
        end else if (highCount == '0) begin
            state_d = PS_STATIC;
        // RULE5 no low time
        end else if (lowCount == '0) begin
            state_d = PS_HIGH;
        // RULE2 RULE3 high slots first
        end else begin
            state_d = ({1'b0, highCount} > slot_d) ? PS_HIGH : PS_LOW;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCnt_q <= 10'h000;
            slot_q   <= 8'h00;
            state_q  <= PS_STATIC;
        end else if (ce) begin
            preCnt_q <= preCnt_d;
            slot_q   <= slot_d;
            state_q  <= state_d;
        end
    end

    assign pwmPin = (state_q == PS_HIGH);

    ////////////////////////////////////////////////////////////////
    sequence sHighNoHc;
        ce && levelHigh && highCount == '0;
    endsequence

    a_static_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        sHighNoHc |=> !pwmPin) else $error("high count zero not static low");

    a_static_high: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        ce && levelHigh && highCount != '0 && lowCount == '0 |=> pwmPin)
        else $error("low count zero not static high");

    a_both_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        sHighNoHc and (lowCount == '0) |=> !pwmPin)
        else $error("both counts zero not static low");

    a_phase_match: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        ce && levelHigh && highCount != '0 && lowCount != '0
        |=> pwmPin == ({1'b0, $past(highCount)} > slot_q))
        else $error("pwm phase disagrees with slot");

    a_tick_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        ce && timeBase == 2'h0 && preCnt_q == 10'(TB_CYC0 - 11'h001) |=> preCnt_q == 10'h000)
        else $error("time base tick at wrong count");
endmodule : plc_pwm_gen
`default_nettype wire

/* File: logic/plc_regs.sv */
// Register bank for PWM high-level encoding, CRC settings and test DAC.
// Assumes a plain strobe port on clk; read data one cycle after strobe.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module plc_regs
    import plc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [15:0] rdData,
    input  wire logic        levelHigh,
    output logic             pwmPin,
    output logic      [2:0]  testDacCode,
    output logic             section2CrcCheckEnable,
    output logic             section1Fault,
    output logic             section2Fault,
    output logic      [1:0]  secondGroupFormat,
    output logic      [1:0]  secondGroupDirection,
    output logic      [1:0]  secondGroupPin0TimeBase,
    output logic      [1:0]  secondGroupPin1TimeBase,
    output logic      [1:0]  secondGroupOutValue
);
    logic [15:0] pwmTb_q, pwmTb_d;
    logic [15:0] lhPwm_q, lhPwm_d;
    logic [15:0] spare_q, spare_d;
    logic [15:0] crc1_q, crc1_d;
    logic [15:0] crc2Tdac_q, crc2Tdac_d;
    logic [15:0] gpioA_q, gpioA_d;
    logic [15:0] crcCtrl_q, crcCtrl_d;
    logic [15:0] crc2_q, crc2_d;
    logic [15:0] rdData_q, rdData_d;
    logic        fault1_q, fault1_d;
    logic        fault2_q, fault2_d;
    logic [15:0] calc1;
    logic [15:0] calc2;
    logic        wrEn;

    ////////////////////////////////////////////////////////////////
    // Masked write keeps fixed bits intact
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] nw,
        input logic [15:0] mask
    );
        merge = (old & ~mask) | (nw & mask);
    endfunction : merge

    // Bitwise CRC-16 step over one register word
    function automatic logic [15:0] crcWord(
        input logic [15:0] crc,
        input logic [15:0] word
    );
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            if (c[15] ^ word[i]) begin
                c = {c[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crcWord = c;
    endfunction : crcWord

    ////////////////////////////////////////////////////////////////
    assign wrEn = ce && wrStb;

    always_comb begin
        pwmTb_d    = pwmTb_q;
        lhPwm_d    = lhPwm_q;
        spare_d    = spare_q;
        crc1_d     = crc1_q;
        crc2Tdac_d = crc2Tdac_q;
        gpioA_d    = gpioA_q;
        crcCtrl_d  = crcCtrl_q;
        crc2_d     = crc2_q;
        if (wrEn) begin
            unique case (addr)
                // RULE13 time base field only
                ADDR_PWM_TB: begin
                    pwmTb_d = merge(pwmTb_q, wrData, WM_PWM_TB);
                end
                // RULE14 bits 15:14 stay zero
                ADDR_LH_PWM: begin
                    lhPwm_d = merge(lhPwm_q, wrData, WM_LH_PWM);
                end
                // RULE7 plain storage
                ADDR_SPARE: begin
                    spare_d = wrData;
                end
                // RULE8 expected CRC
                ADDR_CRC1: begin
                    crc1_d = wrData;
                end
                // RULE11 RULE14 reserved middle ignored
                ADDR_CRC2_TDAC: begin
                    crc2Tdac_d = merge(crc2Tdac_q, wrData, WM_CRC2_TDAC);
                end
                // RULE12 top bit fixed
                ADDR_GPIOA: begin
                    gpioA_d = merge(gpioA_q, wrData, WM_GPIOA);
                end
                ADDR_CRC_CTRL: begin
                    crcCtrl_d = merge(crcCtrl_q, wrData, WM_CRC_CTRL);
                end
                ADDR_CRC2: begin
                    crc2_d = wrData;
                end
                default: begin
                    crc2_d = crc2_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwmTb_q    <= RST_PWM_TB;
            lhPwm_q    <= RST_LH_PWM;
            spare_q    <= RST_SPARE;
            crc1_q     <= RST_CRC1;
            crc2Tdac_q <= RST_CRC2_TDAC;
            gpioA_q    <= RST_GPIOA;
            crcCtrl_q  <= RST_CRC_CTRL;
            crc2_q     <= RST_CRC2;
        end else if (ce) begin
            pwmTb_q    <= pwmTb_d;
            lhPwm_q    <= lhPwm_d;
            spare_q    <= spare_d;
            crc1_q     <= crc1_d;
            crc2Tdac_q <= crc2Tdac_d;
            gpioA_q    <= gpioA_d;
            crcCtrl_q  <= crcCtrl_d;
            crc2_q     <= crc2_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks only the words this bank holds; a full map would chain more
    always_comb begin
        calc1 = crcWord(CRC_INIT, pwmTb_q);
        calc1 = crcWord(calc1, lhPwm_q);
        calc1 = crcWord(calc1, spare_q);
        calc2 = crcWord(CRC_INIT, crc2Tdac_q);
        calc2 = crcWord(calc2, gpioA_q);
    end

    // RULE15 RULE9 mismatch only counts when enabled
    always_comb begin
        fault1_d = crcCtrl_q[CRC1_EN_BIT] && (calc1 != crc1_q);
        fault2_d = crc2Tdac_q[CRC2_EN_BIT] && (calc2 != crc2_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault1_q <= 1'b0;
            fault2_q <= 1'b0;
        end else if (ce) begin
            fault1_q <= fault1_d;
            fault2_q <= fault2_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Unmapped addresses read zero
    always_comb begin
        rdData_d = rdData_q;
        if (ce && rdStb) begin
            unique case (addr)
                ADDR_PWM_TB:    rdData_d = pwmTb_q;
                ADDR_LH_PWM:    rdData_d = lhPwm_q;
                ADDR_SPARE:     rdData_d = spare_q;
                ADDR_CRC1:      rdData_d = crc1_q;
                ADDR_CRC2_TDAC: rdData_d = crc2Tdac_q;
                ADDR_GPIOA:     rdData_d = gpioA_q;
                ADDR_CRC_CTRL: begin
                    rdData_d                = crcCtrl_q;
                    rdData_d[FAULT1_BIT]    = fault1_q;
                    rdData_d[FAULT2_BIT]    = fault2_q;
                end
                ADDR_CRC2:      rdData_d = crc2_q;
                default:        rdData_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_q <= 16'h0000;
        end else if (ce) begin
            rdData_q <= rdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign rdData                  = rdData_q;
    assign section1Fault           = fault1_q;
    assign section2Fault           = fault2_q;
    // RULE9 enable to the CRC logic
    assign section2CrcCheckEnable  = crc2Tdac_q[CRC2_EN_BIT];
    // RULE10 test DAC code
    assign testDacCode             = crc2Tdac_q[TDAC_LSB +: TDAC_W];
    assign secondGroupFormat       = gpioA_q[GA_FMT_LSB +: 2];
    assign secondGroupDirection    = gpioA_q[GA_DIR_LSB +: 2];
    assign secondGroupPin0TimeBase = gpioA_q[GA_TB0_LSB +: 2];
    assign secondGroupPin1TimeBase = gpioA_q[GA_TB1_LSB +: 2];
    assign secondGroupOutValue     = gpioA_q[GA_DAT_LSB +: 2];

    // RULE1 RULE2 RULE3 encoder fed from the bank
    plc_pwm_gen u_pwm (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .levelHigh (levelHigh),
        .highCount (lhPwm_q[LH_HC_LSB +: CNT_W]),
        .lowCount  (lhPwm_q[LH_LC_LSB +: CNT_W]),
        .timeBase  (pwmTb_q[TB_LSB +: 2]),
        .pwmPin    (pwmPin)
    );

    ////////////////////////////////////////////////////////////////
    sequence sWr(logic [7:0] a);
        ce && wrStb && addr == a;
    endsequence

    sequence sRd(logic [7:0] a);
        ce && rdStb && addr == a;
    endsequence

    a_lh_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        sWr(ADDR_LH_PWM) |=> lhPwm_q == {2'b00, $past(wrData[13:0])})
        else $error("high level pwm write not stored");

    a_tdac_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        sWr(ADDR_CRC2_TDAC) |=> testDacCode == $past(wrData[2:0]))
        else $error("test dac code not stored");

    a_crc2_enable: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        sWr(ADDR_CRC2_TDAC) |=> section2CrcCheckEnable == $past(wrData[15]))
        else $error("section 2 crc enable not stored");

    a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        sRd(ADDR_CRC2_TDAC) |=> rdData[14:3] == 12'h000)
        else $error("reserved bits read nonzero");

    a_gpioa_fix: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        sRd(ADDR_GPIOA) |=> rdData[15] && rdData[14:0] == $past(gpioA_q[14:0]))
        else $error("second group config read wrong");

    a_spare_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        !(ce && wrStb && addr == ADDR_SPARE) |=> $stable(spare_q))
        else $error("spare register changed without write");

    a_crc1_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        sWr(ADDR_CRC1) ##1 sRd(ADDR_CRC1) |=> rdData == $past(wrData, 2))
        else $error("section 1 crc readback wrong");

    a_fault2_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        ce && crc2Tdac_q[CRC2_EN_BIT] && calc2 != crc2_q |=> section2Fault)
        else $error("section 2 crc mismatch not flagged");

    a_fault_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        ce && !crc2Tdac_q[CRC2_EN_BIT] |=> !section2Fault)
        else $error("section 2 fault while disabled");

    a_lh_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        sRd(ADDR_LH_PWM) |=> rdData[15:14] == 2'b00)
        else $error("high level pwm reserved bits nonzero");
endmodule : plc_regs
`default_nettype wire

/* File: test/plc_regs_bench.sv */
// Self-checking bench for the PWM level and CRC configuration bank.
// Assumes plc_regs as top, 20 MHz clk, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module plc_regs_bench
    import plc_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic        wrStb;
    logic        rdStb;
    logic [15:0] rdData;
    logic        levelHigh;
    logic        pwmPin;
    logic [2:0]  testDacCode;
    logic        crc2En;
    logic        fault1;
    logic        fault2;
    logic [1:0]  grpFmt;
    logic [1:0]  grpDir;
    logic [1:0]  grpTb0;
    logic [1:0]  grpTb1;
    logic [1:0]  grpOut;
    int          errorCnt;
    int          totalChecks;
    int          cycles;

    plc_regs DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .levelHigh(levelHigh),
        .pwmPin(pwmPin), .testDacCode(testDacCode), .section2CrcCheckEnable(crc2En),
        .section1Fault(fault1), .section2Fault(fault2), .secondGroupFormat(grpFmt),
        .secondGroupDirection(grpDir), .secondGroupPin0TimeBase(grpTb0),
        .secondGroupPin1TimeBase(grpTb1), .secondGroupOutValue(grpOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;

    // Ceiling well above the longest PWM sweep
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
        #1;
    endtask : wr

    task automatic chkRd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        `CHK(rdData, exp)
    endtask : chkRd

    // Bench copy of the section checksum, MSB first
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction : crcStep

    task automatic waitChk(input logic e1, input logic e2);
        repeat (2) @(posedge clk);
        #1;
        `CHK({fault1, fault2}, {e1, e2})
    endtask : waitChk

    ////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        `CHK({pwmPin, testDacCode, crc2En, fault1, fault2}, 7'h00) // outputs at reset
        chkRd(ADDR_LH_PWM, 16'h3f80);
        chkRd(ADDR_SPARE, 16'h5555);    // spare reset pattern
        chkRd(ADDR_CRC1, 16'h0000);     // expected crc reset
        chkRd(ADDR_CRC2_TDAC, 16'h0000); // code zero at reset
        chkRd(ADDR_GPIOA, 16'h8000);    // group config reset
        chkRd(8'h60, 16'h0000);
    endtask : testReset

    task automatic testCrc();
        logic [15:0] c1;
        logic [15:0] c2;
        c1 = crcStep(crcStep(crcStep(CRC_INIT, 16'h0000), 16'h3f80), 16'h5555);
        c2 = crcStep(crcStep(CRC_INIT, 16'h8000), 16'h8000);
        wr(ADDR_CRC2, c2);
        wr(ADDR_CRC2_TDAC, 16'h8000);
        `CHK(crc2En, 1'b1)              // enable bit follows write
        waitChk(1'b0, 1'b0);            // matching section 2
        wr(ADDR_CRC2, ~c2);
        waitChk(1'b0, 1'b1);            // mismatch section 2
        wr(ADDR_CRC1, c1);
        wr(ADDR_CRC_CTRL, 16'h8000);
        waitChk(1'b0, 1'b1);            // matching section 1
        wr(ADDR_CRC1, ~c1);
        waitChk(1'b1, 1'b1);            // mismatch section 1
        chkRd(ADDR_CRC1, ~c1);          // stored crc read back
        chkRd(ADDR_CRC_CTRL, 16'h8003);
        wr(ADDR_CRC_CTRL, 16'h0000);
        wr(ADDR_CRC2_TDAC, 16'h0000);
        waitChk(1'b0, 1'b0);            // disabled check quiet
    endtask : testCrc

    task automatic testRegs();
        // Write then read with no idle cycle between the strobes
        @(posedge clk);
        addr   <= ADDR_CRC1;
        wrData <= 16'h1234;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
        rdStb  <= 1'b1;
        @(posedge clk);
        rdStb  <= 1'b0;
        #1;
        `CHK(rdData, 16'h1234)          // back to back readback
        wr(ADDR_SPARE, 16'ha5c3);
        chkRd(ADDR_SPARE, 16'ha5c3);    // spare read write
        wr(ADDR_LH_PWM, 16'hffff);
        chkRd(ADDR_LH_PWM, 16'h3fff);   // reserved top bits
        wr(ADDR_CRC2_TDAC, 16'hffff);
        chkRd(ADDR_CRC2_TDAC, 16'h8007); // reserved bits read zero
        `CHK({crc2En, testDacCode}, 4'hf) // enable and code set
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CRC2_TDAC, 16'(i));
            `CHK({crc2En, testDacCode}, 4'(i)) // every dac code
        end
        wr(ADDR_GPIOA, 16'h0000);
        chkRd(ADDR_GPIOA, 16'h8000);    // bit 15 stays one
        wr(ADDR_GPIOA, 16'h1a96);
        chkRd(ADDR_GPIOA, 16'h9a96);    // spare and fields kept
        `CHK({grpFmt, grpDir, grpTb1, grpTb0, grpOut}, 10'h2a6) // field outputs
        // Strobe with clock enable low must not land
        @(posedge clk);
        ce     <= 1'b0;
        addr   <= ADDR_SPARE;
        wrData <= 16'h0000;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
        ce     <= 1'b1;
        chkRd(ADDR_SPARE, 16'ha5c3);    // value unchanged
    endtask : testRegs

    ////////////////////////////////////////////////////////////////////////////
    // Whole periods only, so the free-running phase cannot skew counts
    task automatic pwmCase(input logic [1:0] tb, input logic [6:0] hc, input logic [6:0] lc,
                           input logic lvl, input int settle, input int n,
                           input int expHi, input int expRise);
        logic [15:0] hi;
        logic [15:0] rise;
        logic        prev;
        wr(ADDR_PWM_TB, {tb, 14'h0000});
        wr(ADDR_LH_PWM, {2'b00, hc, lc});
        @(posedge clk);
        levelHigh <= lvl;
        repeat (settle) @(posedge clk);
        #1;
        prev = pwmPin;
        hi   = 16'h0000;
        rise = 16'h0000;
        repeat (n) begin
            @(posedge clk);
            #1;
            hi   = hi + {15'h0000, pwmPin};
            rise = rise + {15'h0000, (~prev & pwmPin)};
            prev = pwmPin;
        end
        `CHK({hi, rise}, {16'(expHi), 16'(expRise)}) // period and duty
    endtask : pwmCase

    task automatic testPwm();
        for (int t = 0; t < 4; t++) begin
            pwmCase(2'(t), 7'd1, 7'd1, 1'b1, 64 << (2 * t), 64 << (2 * t),
                    32 << (2 * t), 2); // each time base
        end
        pwmCase(2'b00, 7'd3, 7'd1, 1'b1, 4200, 128, 96, 2); // high slots
        pwmCase(2'b00, 7'd1, 7'd3, 1'b1, 200, 128, 32, 2); // low slots
        pwmCase(2'b00, 7'd0, 7'd5, 1'b1, 200, 200, 0, 0); // static low
        pwmCase(2'b00, 7'd5, 7'd0, 1'b1, 200, 200, 200, 0); // static high
        pwmCase(2'b00, 7'd0, 7'd0, 1'b1, 200, 200, 0, 0); // both zero low
        pwmCase(2'b00, 7'd1, 7'd1, 1'b0, 200, 200, 0, 0);
    endtask : testPwm

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        ce          = 1'b1;
        addr        = 8'h00;
        wrData      = 16'h0000;
        wrStb       = 1'b0;
        rdStb       = 1'b0;
        levelHigh   = 1'b0;
        errorCnt    = 0;
        totalChecks = 0;
        cycles      = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        testReset();
        testCrc();
        testRegs();
        testPwm();
        summarize();
    end
endmodule : plc_regs_bench
`default_nettype wire
